// >>> core/pwr_switchover_monitor.sv
// supply switchover, stamping and supply flags with an AXI4-Lite register file
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "pwr_monitor_cfg.svh"
// Overview of operation
// - go to backup only when main below backup-minus-hysteresis and below trip
// - return to main when above backup-plus-hysteresis or above trip-plus-hysteresis
// - host interface refuses access while running on backup supply
// - other outputs and timekeeping stay active on backup unless disabled
// - stamp time on switch to backup and on switch back to main
// - keep earliest power-down stamp; overwrite power-up stamp each return
// - writing clear_stamps as one clears both stamps for a new capture
// - temperature compensation runs on backup only with backup_temp_sense_enable
// - set total power fail flag on start after loss of both supplies
// - six selectable brownout levels compared continuously against main supply
// - brownout below selected level sets low main supply flag
// - brownout leaves host interface running; only switchover disables it
// - battery flags: first level alone between levels, both below second
// - battery flags frozen while on backup supply
// - battery measurement runs on main supply while temp_sense_enable is set
module pwr_switchover_monitor #(
   parameter int DEBOUNCE_CYC = `PM_DEBOUNCE_CYC,
   parameter int TIME_W       = 32
) (
   // clock, reset, enable
   input  wire logic                               sys_clk,
   input  wire logic                               rst,
   input  wire logic                               clkEn,
   // analogue comparator results
   input  wire pwr_monitor_pkg::switch_cmp_t       switchCmp,
   input  wire logic [`PM_LEVEL_COUNT-1:0]          brownCmp,
   input  wire pwr_monitor_pkg::batt_cmp_t         battCmp,
   input  wire logic                               coldStart,
   // calendar time from the timekeeper
   input  wire logic [TIME_W-1:0]                  calTime,
   // enables to the rest of the chip
   output logic                                    backupMode,
   output logic                                    tempCompRun,
   output logic                                    battMeasure,
   output logic                                    freqOutEn,
   output logic                                    alarmEn,
   output logic                                    irq,
   // AXI4-Lite slave
   input  wire logic [`PM_ADDR_W-1:0]               awaddr,
   input  wire logic                               awvalid,
   output logic                                    awready,
   input  wire logic [31:0]                        wdata,
   input  wire logic [3:0]                         wstrb,
   input  wire logic                               wvalid,
   output logic                                    wready,
   output logic [1:0]                              bresp,
   output logic                                    bvalid,
   input  wire logic                               bready,
   input  wire logic [`PM_ADDR_W-1:0]               araddr,
   input  wire logic                               arvalid,
   output logic                                    arready,
   output logic [31:0]                             rdata,
   output logic [1:0]                              rresp,
   output logic                                    rvalid,
   input  wire logic                               rready
);
   localparam int CMP_W = 4 + `PM_LEVEL_COUNT + 2;

   logic [CMP_W-1:0]                cmpClean;
   pwr_monitor_pkg::switch_cmp_t    swc;
   logic [`PM_LEVEL_COUNT-1:0]       brc;
   pwr_monitor_pkg::batt_cmp_t      btc;
   pwr_monitor_pkg::supply_mode_t   mode_q;
   pwr_monitor_pkg::pwr_flags_t     flags_q;
   logic [`PM_ST_W-1:0]              status_q;
   logic [`PM_ST_W-1:0]              mask_q;
   logic [`PM_CTL_W-1:0]             ctl_q;
   logic [`PM_LEVEL_W-1:0]           level_q;
   logic [TIME_W-1:0]               downStamp_q;
   logic [TIME_W-1:0]               upStamp_q;
   logic                            downHeld_q;
   logic                            coldSeen_q;
   logic                            goBackup;
   logic                            goMain;
   logic                            brownNow;
   logic                            clearStamps;
   logic                            clearFail;
   logic [`PM_ADDR_W-1:0]            awAddr_q;
   logic                            awHave_q;
   logic [31:0]                     wData_q;
   logic [3:0]                      wStrb_q;
   logic                            wHave_q;
   logic                            doWrite;
   logic                            hostOn;
   logic                            stampDown;
   logic                            stampUp;

   cmp_debounce #(
      .WIDTH  (CMP_W),
      .STABLE (DEBOUNCE_CYC)
   ) u_debounce (
      .sysClk   (sys_clk),
      .rst      (rst),
      .clkEn    (clkEn),
      .rawIn    ({switchCmp, brownCmp, battCmp}),
      .cleanOut (cmpClean)
   );

   assign swc = pwr_monitor_pkg::switch_cmp_t'(cmpClean[CMP_W-1 -: 4]);
   assign brc = cmpClean[2 +: `PM_LEVEL_COUNT];
   assign btc = pwr_monitor_pkg::batt_cmp_t'(cmpClean[1:0]);

   assign goBackup = swc.belowBackupMinusHyst && swc.belowTrip;
   assign goMain   = swc.aboveBackupPlusHyst || swc.aboveTripPlusHyst;
   // the bus keeps answering on backup, with SLVERR, so the host never hangs
   assign hostOn   = (mode_q == pwr_monitor_pkg::MODE_MAIN);

   // a clear meeting a fresh switch-down still keeps the new stamp
   assign stampDown = (mode_q == pwr_monitor_pkg::MODE_MAIN) && goBackup && (!downHeld_q || clearStamps);
   assign stampUp   = (mode_q == pwr_monitor_pkg::MODE_BACKUP) && goMain;

   // selected brownout level; codes beyond the sixth fall back to the last
   always_comb begin
      if (level_q < `PM_LEVEL_W'(`PM_LEVEL_COUNT)) begin
         brownNow = brc[level_q];
      end else begin
         brownNow = brc[`PM_LEVEL_COUNT-1];
      end
   end

   // supply mode state machine
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_q <= pwr_monitor_pkg::MODE_MAIN;
      end else if (clkEn) begin
         case (mode_q)
            pwr_monitor_pkg::MODE_MAIN: begin
               if (goBackup) begin
                  mode_q <= pwr_monitor_pkg::MODE_BACKUP;
               end
            end
            pwr_monitor_pkg::MODE_BACKUP: begin
               if (goMain) begin
                  mode_q <= pwr_monitor_pkg::MODE_MAIN;
               end
            end
            default: mode_q <= pwr_monitor_pkg::MODE_MAIN;
         endcase
      end
   end

   // switchover stamps
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         downStamp_q <= '0;
         upStamp_q   <= '0;
         downHeld_q  <= 1'b0;
      end else if (clkEn) begin
         if (stampDown) begin
            downStamp_q <= calTime;
            downHeld_q  <= 1'b1;
         end else if (clearStamps) begin
            downStamp_q <= '0;
            downHeld_q  <= 1'b0;
         end
         if (stampUp) begin
            upStamp_q <= calTime;
         end else if (clearStamps) begin
            upStamp_q <= '0;
         end
      end
   end

   // supply flags; battery flags update only on main with a measurement running
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flags_q    <= '0;
         coldSeen_q <= 1'b0;
      end else if (clkEn) begin
         // coldStart is looked at once, on the first enabled edge after reset
         coldSeen_q <= 1'b1;
         if (!coldSeen_q && coldStart) begin
            flags_q.totalPowerFail <= 1'b1;
         end else if (clearFail) begin
            flags_q.totalPowerFail <= 1'b0;
         end
         flags_q.lowMainSupply <= brownNow;
         if (hostOn && ctl_q[`PM_CTL_TEMP_SENSE]) begin
            flags_q.batteryBelowFirstLevel  <= btc.belowFirstLevel || btc.belowSecondLevel;
            flags_q.batteryBelowSecondLevel <= btc.belowSecondLevel;
         end
      end
   end

   // function enables for the rest of the chip
   // enables follow the mode one cycle late, in step with backupMode
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         backupMode  <= 1'b0;
         tempCompRun <= 1'b0;
         battMeasure <= 1'b0;
         freqOutEn   <= 1'b1;
         alarmEn     <= 1'b1;
      end else if (clkEn) begin
         backupMode  <= !hostOn;
         tempCompRun <= ctl_q[`PM_CTL_TEMP_SENSE] && (hostOn || ctl_q[`PM_CTL_BACKUP_TEMP]);
         battMeasure <= ctl_q[`PM_CTL_TEMP_SENSE] && hostOn;
         freqOutEn   <= hostOn || !ctl_q[`PM_CTL_FREQ_BACKUP];
         alarmEn     <= hostOn || !ctl_q[`PM_CTL_ALARM_BACKUP];
      end
   end

   // sticky events, set wins over write-one clear
   logic [`PM_ST_W-1:0] evt;
   logic [`PM_ST_W-1:0] w1c;
   always_comb begin
      evt = '0;
      evt[`PM_ST_SWITCH_DOWN] = (mode_q == pwr_monitor_pkg::MODE_MAIN) && goBackup;
      evt[`PM_ST_SWITCH_UP]   = stampUp;
      evt[`PM_ST_BROWNOUT]    = brownNow && !flags_q.lowMainSupply;
      evt[`PM_ST_BATT_LOW]    = hostOn && ctl_q[`PM_CTL_TEMP_SENSE] && btc.belowFirstLevel
                                && !flags_q.batteryBelowFirstLevel;
      w1c = '0;
      if (doWrite && hostOn && awAddr_q == `PM_OFF_STATUS && wStrb_q[0]) begin
         w1c = wData_q[`PM_ST_W-1:0];
      end
   end

   // irq follows the next status value, so it lags by no extra cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         status_q <= '0;
         irq      <= 1'b0;
      end else if (clkEn) begin
         status_q <= (status_q & ~w1c) | evt;
         irq      <= |(((status_q & ~w1c) | evt) & mask_q);
      end
   end

   // write channel capture; either order of address and data
   assign doWrite = awHave_q && wHave_q && !bvalid;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         awHave_q <= 1'b0;
         wHave_q  <= 1'b0;
         awAddr_q <= '0;
         wData_q  <= '0;
         wStrb_q  <= '0;
         awready  <= 1'b0;
         wready   <= 1'b0;
         bvalid   <= 1'b0;
         bresp    <= `PM_RESP_OKAY;
      end else if (clkEn) begin
         // ready is a one-cycle pulse so a held valid is taken only once
         awready <= !awHave_q && !awready;
         wready  <= !wHave_q && !wready;
         if (awvalid && awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= awaddr;
            awready  <= 1'b0;
         end
         if (wvalid && wready) begin
            wHave_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
            wready  <= 1'b0;
         end
         if (doWrite) begin
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
            bvalid   <= 1'b1;
            bresp    <= hostOn ? `PM_RESP_OKAY : `PM_RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   assign clearStamps = doWrite && hostOn && awAddr_q == `PM_OFF_CONTROL && wStrb_q[0]
                        && wData_q[`PM_CTL_CLEAR_STAMP];
   assign clearFail   = doWrite && hostOn && awAddr_q == `PM_OFF_FLAGS && wStrb_q[0] && !wData_q[0];

   // writable registers; refused while on backup supply
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctl_q   <= `PM_CTL_RESET;
         mask_q  <= `PM_MASK_RESET;
         level_q <= '0;
      end else if (clkEn && doWrite && hostOn && wStrb_q[0]) begin
         case (awAddr_q)
            `PM_OFF_MASK:    mask_q  <= wData_q[`PM_ST_W-1:0];
            `PM_OFF_CONTROL: begin
               // clear_stamps acts as a strobe and is never stored
               ctl_q <= wData_q[`PM_CTL_W-1:0];
               ctl_q[`PM_CTL_CLEAR_STAMP] <= 1'b0;
            end
            `PM_OFF_LEVEL:   level_q <= wData_q[`PM_LEVEL_W-1:0];
            default: ;
         endcase
      end
   end

   // read channel
   logic [31:0] rdMux;
   logic        rdHit;
   // araddr holds until taken, so the mux reads it directly
   always_comb begin
      rdMux = 32'h0000_0000;
      rdHit = 1'b1;
      case (araddr)
         `PM_OFF_STATUS:     rdMux[`PM_ST_W-1:0]    = status_q;
         `PM_OFF_MASK:       rdMux[`PM_ST_W-1:0]    = mask_q;
         `PM_OFF_CONTROL:    rdMux[`PM_CTL_W-1:0]   = ctl_q;
         `PM_OFF_LEVEL:      rdMux[`PM_LEVEL_W-1:0] = level_q;
         `PM_OFF_TIME:       rdMux[TIME_W-1:0]      = calTime;
         `PM_OFF_DOWN_STAMP: rdMux[TIME_W-1:0]      = downStamp_q;
         `PM_OFF_UP_STAMP:   rdMux[TIME_W-1:0]      = upStamp_q;
         `PM_OFF_FLAGS:      rdMux[4:0] = {!hostOn, flags_q};
         default:            rdHit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `PM_RESP_OKAY;
      end else if (clkEn) begin
         arready <= !rvalid && !arready;
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            if (!hostOn) begin
               rdata <= 32'h0000_0000;
               rresp <= `PM_RESP_SLVERR;
            end else begin
               rdata <= rdMux;
               rresp <= rdHit ? `PM_RESP_OKAY : `PM_RESP_SLVERR;
            end
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule

// >>> core/pwr_monitor_cfg.svh
// constants for the supply switchover monitor
`ifndef PWR_MONITOR_CFG_SVH
`define PWR_MONITOR_CFG_SVH
`define PM_ADDR_W          8
`define PM_OFF_STATUS      8'h00
`define PM_OFF_MASK        8'h04
`define PM_OFF_CONTROL     8'h08
`define PM_OFF_LEVEL       8'h0C
`define PM_OFF_TIME        8'h10
`define PM_OFF_DOWN_STAMP  8'h14
`define PM_OFF_UP_STAMP    8'h18
`define PM_OFF_FLAGS       8'h1C
`define PM_ST_SWITCH_DOWN  0
`define PM_ST_SWITCH_UP    1
`define PM_ST_BROWNOUT     2
`define PM_ST_BATT_LOW     3
`define PM_ST_W            4
`define PM_CTL_TEMP_SENSE  0
`define PM_CTL_BACKUP_TEMP 1
`define PM_CTL_CLEAR_STAMP 2
`define PM_CTL_FREQ_BACKUP 3
`define PM_CTL_ALARM_BACKUP 4
`define PM_CTL_W           5
`define PM_CTL_RESET       5'h00
`define PM_MASK_RESET      4'h0
`define PM_LEVEL_W         3
`define PM_LEVEL_COUNT     6
`define PM_DEBOUNCE_US     400
`define PM_CLK_MHZ         10
`define PM_DEBOUNCE_CYC    ((`PM_DEBOUNCE_US) * (`PM_CLK_MHZ))
`define PM_RESP_OKAY       2'h0
`define PM_RESP_SLVERR     2'h2
`endif

// >>> core/pwr_monitor_pkg.sv
// types for the supply switchover monitor
package pwr_monitor_pkg;
   typedef enum logic {MODE_MAIN, MODE_BACKUP} supply_mode_t;
   typedef struct packed {
      logic belowBackupMinusHyst;
      logic belowTrip;
      logic aboveBackupPlusHyst;
      logic aboveTripPlusHyst;
   } switch_cmp_t;
   typedef struct packed {
      logic belowFirstLevel;
      logic belowSecondLevel;
   } batt_cmp_t;
   typedef struct packed {
      logic lowMainSupply;
      logic batteryBelowFirstLevel;
      logic batteryBelowSecondLevel;
      logic totalPowerFail;
   } pwr_flags_t;
endpackage

// >>> core/cmp_debounce.sv
// synchroniser and debouncer for comparator results
`timescale 1ns/100ps
`include "pwr_monitor_cfg.svh"
module cmp_debounce #(
   parameter int WIDTH  = 8,
   parameter int STABLE = `PM_DEBOUNCE_CYC
) (
   // clock and reset
   input  wire logic             sysClk,
   input  wire logic             rst,
   input  wire logic             clkEn,
   // raw and filtered levels
   input  wire logic [WIDTH-1:0] rawIn,
   output logic      [WIDTH-1:0] cleanOut
);
   localparam int CW = $clog2(STABLE + 1);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic          meta_q;
         logic          sync_q;
         logic [CW-1:0] cnt_q;
         logic          out_q;
         always_ff @(posedge sysClk) begin
            if (rst) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
               cnt_q  <= '0;
               out_q  <= 1'b0;
            end else if (clkEn) begin
               meta_q <= rawIn[i];
               sync_q <= meta_q;
               if (sync_q == out_q) begin
                  cnt_q <= '0;
               end else if (cnt_q == CW'(STABLE - 1)) begin
                  cnt_q <= '0;
                  out_q <= sync_q;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
         end
         assign cleanOut[i] = out_q;
      end
   endgenerate
endmodule

// >>> tb/pwr_switchover_monitor_sva.sv
// port-level assertions for the supply switchover monitor
`timescale 1ns/100ps
`include "pwr_monitor_cfg.svh"
module pwr_switchover_monitor_sva (
   // clock and reset
   input wire logic                         sys_clk,
   input wire logic                         rst,
   // supply side
   input wire pwr_monitor_pkg::switch_cmp_t switchCmp,
   input wire logic                         backupMode,
   input wire logic                         battMeasure,
   input wire logic                         freqOutEn,
   input wire logic                         alarmEn,
   input wire logic                         irq,
   // bus handshakes
   input wire logic                         awvalid,
   input wire logic                         awready,
   input wire logic                         bvalid,
   input wire logic [1:0]                   bresp,
   input wire logic                         arvalid,
   input wire logic                         arready,
   input wire logic                         rvalid,
   input wire logic [31:0]                  rdata,
   input wire logic [1:0]                   rresp
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // raw condition must have stood well before the switch
   sequence s_steady_low;
      $past(switchCmp.belowBackupMinusHyst && switchCmp.belowTrip, 2) &&
      $past(switchCmp.belowBackupMinusHyst && switchCmp.belowTrip, 4);
   endsequence
   sequence s_ar_taken;
      arvalid && arready;
   endsequence
   sequence s_aw_taken;
      awvalid && awready;
   endsequence
   a_enter_backup: assert property ($rose(backupMode) |-> s_steady_low)
      else $error("backup entered without both low conditions");
   a_leave_backup: assert property ($fell(backupMode) |->
      $past(switchCmp.aboveBackupPlusHyst || switchCmp.aboveTripPlusHyst, 2))
      else $error("backup left without a return condition");
   a_refuse_write: assert property (bvalid && backupMode |-> bresp == `PM_RESP_SLVERR)
      else $error("write answered normally on backup");
   a_refuse_read: assert property (rvalid && backupMode |->
      rresp == `PM_RESP_SLVERR && rdata == 32'h0)
      else $error("read answered normally on backup");
   a_batt_frozen: assert property (backupMode && $past(backupMode) |-> !battMeasure)
      else $error("battery measured on backup");
   a_main_outputs: assert property (!backupMode && !$past(backupMode) && !$past(backupMode, 2) |->
      freqOutEn && alarmEn)
      else $error("outputs disabled on main supply");
   a_reset_state: assert property (disable iff (1'b0) rst |=> !backupMode && !irq && freqOutEn && alarmEn)
      else $error("wrong state after reset");
   a_read_answer: assert property (s_ar_taken |-> ##[1:2] rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_aw_taken |-> ##[1:6] bvalid)
      else $error("write answer late");
endmodule
bind pwr_switchover_monitor pwr_switchover_monitor_sva chk (.sys_clk, .rst, .switchCmp, .backupMode, .battMeasure,
   .freqOutEn, .alarmEn, .irq, .awvalid, .awready, .bvalid, .bresp, .arvalid, .arready, .rvalid, .rdata, .rresp);

// >>> tb/axi_host_model.sv
// AXI4-Lite host model for the register bus
`timescale 1ns/100ps
`include "pwr_monitor_cfg.svh"
module axi_host_model (
   // clock
   input wire logic                   sys_clk,
   // write channels
   output logic [`PM_ADDR_W-1:0]      awaddr,
   output logic                       awvalid,
   input wire logic                   awready,
   output logic [31:0]                wdata,
   output logic [3:0]                 wstrb,
   output logic                       wvalid,
   input wire logic                   wready,
   input wire logic [1:0]             bresp,
   input wire logic                   bvalid,
   output logic                       bready,
   // read channels
   output logic [`PM_ADDR_W-1:0]      araddr,
   output logic                       arvalid,
   input wire logic                   arready,
   input wire logic [31:0]            rdata,
   input wire logic [1:0]             rresp,
   input wire logic                   rvalid,
   output logic                       rready
);
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      wstrb = 4'hF;
   end
   // released payloads are inverted so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~awaddr;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~wdata;
         end
      end while (!(bvalid && bready));
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr <= ~araddr;
         end
      end while (!(rvalid && rready));
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule

// >>> tb/rtc_power_switchover_monitor_tb_top.sv
// self-checking bench for the supply switchover monitor
`timescale 1ns/100ps
`include "pwr_monitor_cfg.svh"
module rtc_power_switchover_monitor_tb_top;
   localparam int DB = 4;
   localparam int SETTLE = DB + 8;
   logic                         sys_clk, rst, clkEn, coldStart;
   pwr_monitor_pkg::switch_cmp_t switchCmp;
   pwr_monitor_pkg::batt_cmp_t   battCmp;
   logic [5:0]                   brownCmp;
   logic [31:0]                  calTime, rv, wdata, rdata;
   logic [1:0]                   resp, bresp, rresp;
   logic                         backupMode, tempCompRun, battMeasure, freqOutEn, alarmEn, irq;
   logic [7:0]                   awaddr, araddr;
   logic                         awvalid, awready, wvalid, wready, bvalid, bready;
   logic                         arvalid, arready, rvalid, rready;
   logic [3:0]                   wstrb;
   int                           error_cnt, tests_run;
   pwr_switchover_monitor #(.DEBOUNCE_CYC(DB)) uut (.sys_clk, .rst, .clkEn, .switchCmp, .brownCmp, .battCmp,
      .coldStart, .calTime, .backupMode, .tempCompRun, .battMeasure, .freqOutEn, .alarmEn, .irq, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready);
   axi_host_model host (.sys_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      host.rd(a, rv, resp);
      chk(rv, exp);
      chk(resp, er);
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      host.wr(a, d, resp);
   endtask
   // drive the switchover comparators and wait for the mode to follow
   task automatic go(input logic [3:0] v, input logic m);
      int n;
      n = 0;
      @(posedge sys_clk);
      switchCmp <= v;
      do begin
         @(posedge sys_clk);
         n++;
      end while ((backupMode !== m || n < SETTLE) && n < 40);
      wt(2);
   endtask
   task automatic t_reset();
      rchk(`PM_OFF_FLAGS, 32'h1, `PM_RESP_OKAY);
      rchk(`PM_OFF_CONTROL, 32'h0, `PM_RESP_OKAY);
      rchk(`PM_OFF_MASK, 32'h0, `PM_RESP_OKAY);
      host.rd(8'h20, rv, resp);
      chk(resp, `PM_RESP_SLVERR);
      wreg(`PM_OFF_FLAGS, 32'h0);
      rchk(`PM_OFF_FLAGS, 32'h0, `PM_RESP_OKAY);
      $display("test reset done");
   endtask
   task automatic t_switch();
      wreg(`PM_OFF_CONTROL, 32'h0B);
      calTime <= 32'h1111_0001;
      go(4'h4, 1'b0);
      chk(backupMode, 1'b0);
      go(4'hC, 1'b1);
      chk(backupMode, 1'b1);
      chk({tempCompRun, freqOutEn, alarmEn}, 3'b101);
      rchk(`PM_OFF_TIME, 32'h0, `PM_RESP_SLVERR);
      wreg(`PM_OFF_MASK, 32'hF);
      chk(resp, `PM_RESP_SLVERR);
      wreg(`PM_OFF_STATUS, 32'hF);
      chk(resp, `PM_RESP_SLVERR);
      calTime <= 32'h2222_0002;
      go(4'h1, 1'b0);
      chk(backupMode, 1'b0);
      rchk(`PM_OFF_DOWN_STAMP, 32'h1111_0001, `PM_RESP_OKAY);
      rchk(`PM_OFF_UP_STAMP, 32'h2222_0002, `PM_RESP_OKAY);
      rchk(`PM_OFF_MASK, 32'h0, `PM_RESP_OKAY);
      rchk(`PM_OFF_STATUS, 32'h3, `PM_RESP_OKAY);
      $display("test switch done");
   endtask
   task automatic t_multi();
      wreg(`PM_OFF_CONTROL, 32'h11);
      calTime <= 32'h3333_0003;
      go(4'hC, 1'b1);
      chk({tempCompRun, freqOutEn, alarmEn}, 3'b010);
      calTime <= 32'h4444_0004;
      go(4'h2, 1'b0);
      chk(backupMode, 1'b0);
      rchk(`PM_OFF_DOWN_STAMP, 32'h1111_0001, `PM_RESP_OKAY);
      rchk(`PM_OFF_UP_STAMP, 32'h4444_0004, `PM_RESP_OKAY);
      wreg(`PM_OFF_CONTROL, 32'h05);
      rchk(`PM_OFF_DOWN_STAMP, 32'h0, `PM_RESP_OKAY);
      rchk(`PM_OFF_UP_STAMP, 32'h0, `PM_RESP_OKAY);
      rchk(`PM_OFF_CONTROL, 32'h01, `PM_RESP_OKAY);
      calTime <= 32'h5555_0005;
      go(4'hC, 1'b1);
      go(4'h1, 1'b0);
      rchk(`PM_OFF_DOWN_STAMP, 32'h5555_0005, `PM_RESP_OKAY);
      $display("test multi done");
   endtask
   task automatic t_irq();
      rchk(`PM_OFF_STATUS, 32'h3, `PM_RESP_OKAY);
      chk(irq, 1'b0);
      wreg(`PM_OFF_MASK, 32'h1);
      wt(2);
      chk(irq, 1'b1);
      wreg(`PM_OFF_STATUS, 32'h1);
      wt(2);
      chk(irq, 1'b0);
      wreg(`PM_OFF_MASK, 32'h2);
      wt(2);
      chk(irq, 1'b1);
      wreg(`PM_OFF_STATUS, 32'hF);
      wt(2);
      chk(irq, 1'b0);
      rchk(`PM_OFF_STATUS, 32'h0, `PM_RESP_OKAY);
      $display("test irq done");
   endtask
   // levels 0..5 and 7, which acts as 5
   task automatic t_brown();
      int idx;
      for (int k = 0; k < 7; k++) begin
         idx = (k == 6) ? 5 : k;
         wreg(`PM_OFF_LEVEL, (k == 6) ? 7 : k);
         @(posedge sys_clk);
         brownCmp <= 6'h01 << idx;
         wt(SETTLE);
         rchk(`PM_OFF_FLAGS, 32'h08, `PM_RESP_OKAY);
         @(posedge sys_clk);
         brownCmp <= ~(6'h01 << idx);
         wt(SETTLE);
         rchk(`PM_OFF_FLAGS, 32'h0, `PM_RESP_OKAY);
      end
      brownCmp <= 6'h00;
      rchk(`PM_OFF_STATUS, 32'h4, `PM_RESP_OKAY);
      $display("test brownout done");
   endtask
   task automatic t_batt();
      wreg(`PM_OFF_CONTROL, 32'h0);
      @(posedge sys_clk);
      battCmp <= 2'b10;
      wt(SETTLE);
      rchk(`PM_OFF_FLAGS, 32'h0, `PM_RESP_OKAY);
      wreg(`PM_OFF_CONTROL, 32'h1);
      wt(SETTLE);
      chk(battMeasure, 1'b1);
      rchk(`PM_OFF_FLAGS, 32'h4, `PM_RESP_OKAY);
      @(posedge sys_clk);
      battCmp <= 2'b11;
      wt(SETTLE);
      rchk(`PM_OFF_FLAGS, 32'h6, `PM_RESP_OKAY);
      rchk(`PM_OFF_STATUS, 32'hC, `PM_RESP_OKAY);
      $display("test battery done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      {rst, clkEn, coldStart} = 3'b111;
      switchCmp = 4'h3;
      battCmp = 2'b00;
      brownCmp = 6'h00;
      calTime = 32'h0;
      error_cnt = 0;
      tests_run = 0;
      wt(8);
      rst <= 1'b0;
      wt(2);
      coldStart <= 1'b0;
      t_reset();
      t_switch();
      t_multi();
      t_irq();
      t_brown();
      t_batt();
      complete_run();
   end
   initial begin
      #3000000;
      error_cnt++;
      complete_run();
   end
endmodule
